/* src/dpsl_flash_guard.sv */
// per-block flash protection levels and the permission check for block commands
// assumes levels live in flash, so reset leaves them alone
`timescale 1ns/10ps
`default_nettype none
module dpsl_flash_guard #(
    parameter int NUM_BLOCKS = 4,
    parameter int BLK_W      = 2
) (
    input  wire logic                       mclk,
    input  wire logic                       set_valid,
    input  wire logic [BLK_W-1:0]           set_block,
    input  wire dpsl_pkg::dpsl_prot_t       set_level,
    input  wire logic                       full_erase,
    input  wire logic [BLK_W-1:0]           chk_block,
    input  wire dpsl_pkg::dpsl_cmd_t        chk_cmd,
    output logic                            chk_permit,
    output logic                            any_prot
);
    import dpsl_pkg::*;

    typedef struct packed {
        logic [NUM_BLOCKS-1:0][1:0] level;
    } dpsl_guard_state_t;

    dpsl_guard_state_t state;
    dpsl_guard_state_t next_state;
    logic [NUM_BLOCKS-1:0] blk_prot;

    function automatic logic op_permitted(input dpsl_prot_t lvl, input dpsl_cmd_t cmd);
        logic ok;
        ok = 1'b0;
        if (lvl == PROT_NONE) begin
            ok = 1'b1;
        end else if (lvl == PROT_VERIFY_ONLY) begin
            ok = (cmd == CMD_BLK_VERIFY);
        end
        return ok;
    endfunction

    generate
        for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
            assign blk_prot[b] = (state.level[b] != PROT_NONE);
        end
    endgenerate

    assign any_prot   = |blk_prot;
    assign chk_permit = op_permitted(state.level[chk_block], chk_cmd);

    always_comb begin
        next_state = state;
        // levels only climb; the single way down is the full erase
        if (set_valid && (set_level > state.level[set_block])) begin
            next_state.level[set_block] = set_level;
        end
        if (full_erase) begin
            next_state.level = '0;
        end
    end

    always_ff @(posedge mclk) begin
        state <= next_state;
    end

endmodule
`default_nettype wire

/* src/dpsl_latch.sv */
// rewritable lock latch: volatile load register in front of nonvolatile cells
// assumes the caller gates writes with its own protection and port checks
`timescale 1ns/10ps
`default_nettype none
module dpsl_latch #(
    // arbitrary key value, not tied to any product
    parameter logic [31:0] KEY_PATTERN = 32'hA5C3_1E69
) (
    input  wire logic                           mclk,
    input  wire logic                           reset_n,
    input  wire logic                           load_valid,
    input  wire logic [dpsl_pkg::KEY_BITS-1:0]  load_data,
    input  wire logic                           commit_req,
    input  wire logic                           erase_req,
    input  wire logic                           write_allowed,
    output logic      [dpsl_pkg::KEY_BITS-1:0]  volatile_key,
    output logic      [dpsl_pkg::KEY_BITS-1:0]  stored_key,
    output logic                                lock_out
);
    import dpsl_pkg::*;

    typedef struct packed {
        logic [KEY_BITS-1:0] vreg;
        logic [KEY_BITS-1:0] nv;
    } dpsl_latch_state_t;

    // power-up value for simulation
    dpsl_latch_state_t state = '0;
    dpsl_latch_state_t next_state;
    logic [CNT_W-1:0]  match_cnt;

    function automatic logic [CNT_W-1:0] ones_count(input logic [KEY_BITS-1:0] v);
        logic [CNT_W-1:0] n;
        n = '0;
        for (int i = 0; i < KEY_BITS; i++) begin
            n = n + CNT_W'(v[i]);
        end
        return n;
    endfunction

    // a few failed cells must not drop the lock, so a super-majority suffices
    assign match_cnt = ones_count(~(state.nv ^ KEY_PATTERN));
    assign lock_out  = (match_cnt >= CNT_W'(MATCH_MIN));

    always_comb begin
        next_state = state;
        if (load_valid && write_allowed) begin
            next_state.vreg = load_data;
        end
        if (commit_req && write_allowed) begin
            next_state.nv = state.vreg;
        end
        // once the cells hold the key the erase request is refused; a commit can still overwrite them
        if (erase_req && write_allowed && !lock_out) begin
            next_state.nv   = NV_ERASED;
            next_state.vreg = KEY_RESET;
        end
    end

    // the cells are nonvolatile: reset clears only the load register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state.vreg <= KEY_RESET;
            state.nv   <= state.nv;
        end else begin
            state <= next_state;
        end
    end

    assign volatile_key = state.vreg;
    assign stored_key   = state.nv;

endmodule
`default_nettype wire

/* src/dpsl_pkg.sv */
// shared constants and types for the debug port security lockout block
// assumes nothing beyond a systemverilog compiler
package dpsl_pkg;

    localparam int KEY_BYTES = 4;
    localparam int KEY_BITS  = KEY_BYTES * 8;
    localparam int MATCH_MIN = 28;
    localparam int CNT_W     = 6;

    localparam logic [KEY_BITS-1:0] KEY_RESET = 32'h0000_0000;
    localparam logic [KEY_BITS-1:0] NV_ERASED = 32'h0000_0000;

    typedef logic [1:0] dpsl_prot_t;
    localparam dpsl_prot_t PROT_NONE        = 2'h0;
    localparam dpsl_prot_t PROT_VERIFY_ONLY = 2'h1;
    localparam dpsl_prot_t PROT_FULL        = 2'h2;

    typedef enum logic [3:0] {
        CMD_LOAD_KEY,
        CMD_COMMIT_KEY,
        CMD_ERASE_LATCH,
        CMD_READ_LATCH,
        CMD_SET_PROT,
        CMD_FULL_ERASE,
        CMD_BLK_ERASE,
        CMD_BLK_PROGRAM,
        CMD_BLK_VERIFY,
        CMD_DEV_PROGRAM,
        CMD_DEV_VERIFY
    } dpsl_cmd_t;

    typedef enum logic {
        PORT_JTAG,
        PORT_SWD
    } dpsl_port_t;

    typedef enum logic [2:0] {
        MEM_FULL_ERASE,
        MEM_BLK_ERASE,
        MEM_BLK_PROGRAM,
        MEM_BLK_VERIFY,
        MEM_DEV_PROGRAM,
        MEM_DEV_VERIFY
    } dpsl_mem_op_t;

endpackage

/* src/dpsl_top.sv */
// debug port security lockout: command gate between the debug ports and memory
// assumes commands arrive decoded from the jtag or swd front end on mclk
//
// Overview of operation
// - The lock latch holds a 32-bit key as four bytes in nonvolatile cells behind a volatile load register.
// - The latch reports locked when at least 28 of its 32 cells match the key pattern.
// - While the sampled lock is set, debug and test mode entry is refused.
// - While locked, nothing can erase or rewrite the latch itself.
// - Lock engages only after load, commit to the cells, and a following reset.
// - The latch output is captured only in reset and that capture alone disables external access.
// - Writing the key is accepted only when no flash protection is set.
// - After the key is written, access stays open until the next reset.
// - The latch contents can be read over the serial wire debug port to identify a protected part.
// - When security is active, the jtag and swd port enables and the test and debug mode enables are all off.
// - A raised protection level comes down only through a full device erase.
// - Block erase, program and verify run only when that block's protection allows it.
// - Either port supports whole-device erase, programming and verification.
`timescale 1ns/10ps
`default_nettype none
module dpsl_top #(
    parameter logic [31:0] KEY_PATTERN = 32'hA5C3_1E69,
    parameter int          NUM_BLOCKS  = 4,
    parameter int          BLK_W       = 2
) (
    input  wire logic                           mclk,
    input  wire logic                           reset_n,
    input  wire logic                           cmd_valid,
    input  wire dpsl_pkg::dpsl_cmd_t            cmd_op,
    input  wire dpsl_pkg::dpsl_port_t           cmd_port,
    input  wire logic [BLK_W-1:0]               cmd_block,
    input  wire logic [dpsl_pkg::KEY_BITS-1:0]  cmd_data,
    output logic                                cmd_ready,
    output logic                                rsp_valid,
    output logic                                rsp_ok,
    output logic      [dpsl_pkg::KEY_BITS-1:0]  rsp_data,
    output logic                                mem_req_valid,
    output dpsl_pkg::dpsl_mem_op_t              mem_req_op,
    output logic      [BLK_W-1:0]               mem_req_block,
    output logic      [dpsl_pkg::KEY_BITS-1:0]  mem_req_data,
    input  wire logic                           mem_done,
    input  wire logic                           mem_ok,
    input  wire logic                           test_mode_req,
    input  wire logic                           debug_mode_req,
    output logic                                test_mode_en,
    output logic                                debug_mode_en,
    output logic                                jtag_port_en,
    output logic                                swd_port_en,
    output logic                                device_locked
);
    import dpsl_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MEM,
        ST_RESP
    } dpsl_fsm_t;

    typedef struct packed {
        dpsl_fsm_t           fsm;
        logic                locked;
        logic                ok;
        logic [KEY_BITS-1:0] data;
        dpsl_mem_op_t        mem_op;
        logic [BLK_W-1:0]    mem_block;
    } dpsl_top_state_t;

    dpsl_top_state_t state;
    dpsl_top_state_t next_state;

    logic                accept;
    logic                port_ok;
    logic                key_write_ok;
    logic                latch_load;
    logic                latch_commit;
    logic                latch_erase;
    logic                latch_lock;
    logic [KEY_BITS-1:0] latch_volatile;
    logic [KEY_BITS-1:0] latch_stored;
    logic                prot_set;
    logic                prot_clear;
    logic                blk_permit;
    logic                any_prot;

    dpsl_latch #(
        .KEY_PATTERN (KEY_PATTERN)
    ) u_latch (
        .mclk          (mclk),
        .reset_n       (reset_n),
        .load_valid    (latch_load),
        .load_data     (cmd_data),
        .commit_req    (latch_commit),
        .erase_req     (latch_erase),
        .write_allowed (key_write_ok),
        .volatile_key  (latch_volatile),
        .stored_key    (latch_stored),
        .lock_out      (latch_lock)
    );

    dpsl_flash_guard #(
        .NUM_BLOCKS (NUM_BLOCKS),
        .BLK_W      (BLK_W)
    ) u_guard (
        .mclk       (mclk),
        .set_valid  (prot_set),
        .set_block  (cmd_block),
        .set_level  (dpsl_prot_t'(cmd_data[1:0])),
        .full_erase (prot_clear),
        .chk_block  (cmd_block),
        .chk_cmd    (cmd_op),
        .chk_permit (blk_permit),
        .any_prot   (any_prot)
    );

    assign cmd_ready = (state.fsm == ST_IDLE);
    assign accept    = cmd_valid && cmd_ready;

    // a locked part answers only the identifying latch read over swd
    assign port_ok = state.locked ? ((cmd_op == CMD_READ_LATCH) && (cmd_port == PORT_SWD)) : 1'b1;
    assign key_write_ok = !any_prot;

    assign latch_load   = accept && port_ok && (cmd_op == CMD_LOAD_KEY);
    assign latch_commit = accept && port_ok && (cmd_op == CMD_COMMIT_KEY);
    assign latch_erase  = accept && port_ok && (cmd_op == CMD_ERASE_LATCH);
    assign prot_set     = accept && port_ok && (cmd_op == CMD_SET_PROT);
    // levels fall only when the whole-device erase has really finished
    assign prot_clear   = (state.fsm == ST_MEM) && mem_done && mem_ok && (state.mem_op == MEM_FULL_ERASE);

    always_comb begin
        next_state = state;
        case (state.fsm)
            ST_IDLE: begin
                if (accept) begin
                    next_state.fsm       = ST_RESP;
                    next_state.ok        = 1'b0;
                    next_state.data      = KEY_RESET;
                    next_state.mem_block = cmd_block;
                    if (port_ok) begin
                        case (cmd_op)
                            CMD_LOAD_KEY,
                            CMD_COMMIT_KEY: begin
                                // the sampled lock is untouched here, so access stays open
                                next_state.ok = key_write_ok;
                            end
                            CMD_ERASE_LATCH: begin
                                next_state.ok = key_write_ok && !latch_lock;
                            end
                            CMD_READ_LATCH: begin
                                next_state.ok   = (cmd_port == PORT_SWD);
                                next_state.data = (cmd_port == PORT_SWD) ? latch_stored : KEY_RESET;
                            end
                            CMD_SET_PROT: begin
                                next_state.ok = 1'b1;
                            end
                            CMD_FULL_ERASE: begin
                                next_state.fsm    = ST_MEM;
                                next_state.mem_op = MEM_FULL_ERASE;
                            end
                            CMD_DEV_PROGRAM: begin
                                next_state.fsm    = any_prot ? ST_RESP : ST_MEM;
                                next_state.mem_op = MEM_DEV_PROGRAM;
                                next_state.data   = cmd_data;
                            end
                            CMD_DEV_VERIFY: begin
                                next_state.fsm    = ST_MEM;
                                next_state.mem_op = MEM_DEV_VERIFY;
                                next_state.data   = cmd_data;
                            end
                            CMD_BLK_ERASE: begin
                                next_state.fsm    = blk_permit ? ST_MEM : ST_RESP;
                                next_state.mem_op = MEM_BLK_ERASE;
                            end
                            CMD_BLK_PROGRAM: begin
                                next_state.fsm    = blk_permit ? ST_MEM : ST_RESP;
                                next_state.mem_op = MEM_BLK_PROGRAM;
                                next_state.data   = cmd_data;
                            end
                            CMD_BLK_VERIFY: begin
                                next_state.fsm    = blk_permit ? ST_MEM : ST_RESP;
                                next_state.mem_op = MEM_BLK_VERIFY;
                                next_state.data   = cmd_data;
                            end
                            default: begin
                                next_state.ok = 1'b0;
                            end
                        endcase
                    end
                end
            end
            ST_MEM: begin
                if (mem_done) begin
                    next_state.fsm  = ST_RESP;
                    next_state.ok   = mem_ok;
                    next_state.data = KEY_RESET;
                end
            end
            ST_RESP: begin
                next_state.fsm = ST_IDLE;
            end
            default: begin
                next_state.fsm = ST_IDLE;
            end
        endcase
    end

    // the lock flag is loaded only while reset is held; no command path reaches it
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state.fsm       <= ST_IDLE;
            state.locked    <= latch_lock;
            state.ok        <= 1'b0;
            state.data      <= KEY_RESET;
            state.mem_op    <= MEM_FULL_ERASE;
            state.mem_block <= '0;
        end else begin
            state        <= next_state;
            state.locked <= state.locked;
        end
    end

    assign rsp_valid     = (state.fsm == ST_RESP);
    assign rsp_ok        = state.ok;
    assign rsp_data      = state.data;
    assign mem_req_valid = (state.fsm == ST_MEM);
    assign mem_req_op    = state.mem_op;
    assign mem_req_block = state.mem_block;
    assign mem_req_data  = state.data;

    // every external port enable hangs off the one flag captured at reset
    assign test_mode_en  = test_mode_req && !state.locked;
    assign debug_mode_en = debug_mode_req && !state.locked;
    assign jtag_port_en  = !state.locked;
    assign swd_port_en   = !state.locked;
    assign device_locked = state.locked;

endmodule
`default_nettype wire

/* verification/dpsl_mem_model.sv */
// memory side model: answers each outstanding request with one done pulse
// assumes mem_req_valid stays high until the done pulse is seen
`timescale 1ns/10ps
`default_nettype none
module dpsl_mem_model (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic mem_req_valid,
    input  wire logic slow,
    input  wire logic fail,
    output logic      mem_done,
    output logic      mem_ok
);
    logic [2:0] cnt;

    // outside the done pulse mem_ok toggles so a stale sample shows up
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cnt      <= 3'h0;
            mem_done <= 1'b0;
            mem_ok   <= 1'b0;
        end else begin
            mem_done <= 1'b0;
            mem_ok   <= ~mem_ok;
            if (mem_req_valid && !mem_done) begin
                if (cnt == (slow ? 3'h4 : 3'h0)) begin
                    cnt      <= 3'h0;
                    mem_done <= 1'b1;
                    mem_ok   <= ~fail;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verification/dpsl_top_assertions.sv */
// concurrent checks on the ports of dpsl_top, bound below
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module dpsl_top_checker
    import dpsl_pkg::*;
(
    input wire logic                          mclk,
    input wire logic                          reset_n,
    input wire logic                          cmd_valid,
    input wire dpsl_pkg::dpsl_cmd_t           cmd_op,
    input wire dpsl_pkg::dpsl_port_t          cmd_port,
    input wire logic                          cmd_ready,
    input wire logic                          rsp_valid,
    input wire logic                          rsp_ok,
    input wire logic [dpsl_pkg::KEY_BITS-1:0] rsp_data,
    input wire logic                          mem_req_valid,
    input wire dpsl_pkg::dpsl_mem_op_t        mem_req_op,
    input wire logic                          mem_done,
    input wire logic                          mem_ok,
    input wire logic                          test_mode_req,
    input wire logic                          debug_mode_req,
    input wire logic                          test_mode_en,
    input wire logic                          debug_mode_en,
    input wire logic                          jtag_port_en,
    input wire logic                          swd_port_en,
    input wire logic                          device_locked
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_take_locked;
        s_take ##0 (device_locked && !(cmd_op == CMD_READ_LATCH && cmd_port == PORT_SWD));
    endsequence
    sequence s_take_jtag_read;
        s_take ##0 (cmd_op == CMD_READ_LATCH && cmd_port == PORT_JTAG);
    endsequence

    chk_locked_gates: assert property (device_locked |-> !test_mode_en && !debug_mode_en
        && !jtag_port_en && !swd_port_en) else $error("port open on locked part");
    chk_open_gates: assert property (!device_locked |-> jtag_port_en && swd_port_en
        && test_mode_en == test_mode_req && debug_mode_en == debug_mode_req) else $error("gate wrong when open");
    chk_lock_stays: assert property ($past(reset_n) && $past(device_locked) |-> device_locked)
        else $error("lock flag dropped outside reset");
    chk_open_stays: assert property ($past(reset_n) && !$past(device_locked) |-> !device_locked)
        else $error("lock flag set outside reset");
    chk_locked_refuse: assert property (s_take_locked |=> rsp_valid && !rsp_ok && !mem_req_valid)
        else $error("locked part accepted command");
    chk_jtag_read: assert property (s_take_jtag_read |=> rsp_valid && !rsp_ok && rsp_data == '0)
        else $error("latch read over jtag");
    chk_mem_wait: assert property (mem_req_valid && !mem_done |=> mem_req_valid && $stable(mem_req_op))
        else $error("memory request dropped early");
    chk_mem_answer: assert property (mem_req_valid && mem_done |=> !mem_req_valid && rsp_valid
        && rsp_ok == $past(mem_ok)) else $error("memory result not returned");
    chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && cmd_ready)
        else $error("answer longer than one cycle");
    cov_locked_take: cover property (s_take_locked);
endmodule
bind dpsl_top dpsl_top_checker u_chk (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_port(cmd_port), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data),
    .mem_req_valid(mem_req_valid), .mem_req_op(mem_req_op), .mem_done(mem_done), .mem_ok(mem_ok),
    .test_mode_req(test_mode_req), .debug_mode_req(debug_mode_req), .test_mode_en(test_mode_en),
    .debug_mode_en(debug_mode_en), .jtag_port_en(jtag_port_en), .swd_port_en(swd_port_en),
    .device_locked(device_locked));
`default_nettype wire

/* verification/dpsl_top_test.sv */
// self-checking bench for dpsl_top with the memory model on the far side
// assumes a 100 mhz clock and commands issued one at a time
`timescale 1ns/10ps
`default_nettype none
module dpsl_top_test;
    import dpsl_pkg::*;
    // arbitrary key value for this bench
    localparam logic [31:0] KEY = 32'h3C5A_0F96;

    logic         mclk, reset_n, cmd_valid, cmd_ready, rsp_valid, rsp_ok;
    dpsl_cmd_t    cmd_op;
    dpsl_port_t   cmd_port;
    logic [1:0]   cmd_block, mem_req_block;
    logic [31:0]  cmd_data, rsp_data, mem_req_data, got_data;
    logic         mem_req_valid, mem_done, mem_ok, slow, fail, got_mem;
    dpsl_mem_op_t mem_req_op, got_op;
    logic         test_mode_req, debug_mode_req, test_mode_en, debug_mode_en;
    logic         jtag_port_en, swd_port_en, device_locked;
    int           error_cnt, compares;

    dpsl_top #(.KEY_PATTERN(KEY)) dut (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_port(cmd_port), .cmd_block(cmd_block), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data), .mem_req_valid(mem_req_valid),
        .mem_req_op(mem_req_op), .mem_req_block(mem_req_block), .mem_req_data(mem_req_data),
        .mem_done(mem_done), .mem_ok(mem_ok), .test_mode_req(test_mode_req), .debug_mode_req(debug_mode_req),
        .test_mode_en(test_mode_en), .debug_mode_en(debug_mode_en), .jtag_port_en(jtag_port_en),
        .swd_port_en(swd_port_en), .device_locked(device_locked));
    dpsl_mem_model u_mem (.mclk(mclk), .reset_n(reset_n), .mem_req_valid(mem_req_valid), .slow(slow),
        .fail(fail), .mem_done(mem_done), .mem_ok(mem_ok));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic do_reset();
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        #1;
    endtask

    task automatic run(input dpsl_cmd_t op, input dpsl_port_t pt, input logic [1:0] blk, input logic [31:0] d,
                       input logic eok, emem, input string m);
        int n;
        got_mem = 1'b0;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        cmd_port  <= pt;
        cmd_block <= blk;
        cmd_data  <= d;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 40; n++) begin
            #1;
            if (mem_req_valid === 1'b1) begin
                got_mem = mem_req_block === blk && mem_req_data === d;
                got_op  = mem_req_op;
            end
            if (rsp_valid === 1'b1) break;
            @(posedge mclk);
        end
        got_data = rsp_data;
        chk(n < 40 && rsp_ok === eok && got_mem === emem, m);
    endtask

    task automatic t_init();
        do_reset();
        run(CMD_FULL_ERASE, PORT_SWD, 2'h0, 32'h0, 1'b1, 1'b1, "full erase");
        run(CMD_ERASE_LATCH, PORT_SWD, 2'h0, 32'h0, 1'b1, 1'b0, "latch erase");
        do_reset();
        chk(device_locked === 1'b0 && jtag_port_en === 1'b1, "blank part locked");
    endtask

    task automatic t_near_miss();
        run(CMD_LOAD_KEY, PORT_SWD, 2'h0, KEY ^ 32'h0000_001F, 1'b1, 1'b0, "load 27");
        run(CMD_COMMIT_KEY, PORT_SWD, 2'h0, 32'h0, 1'b1, 1'b0, "commit 27");
        do_reset();
        chk(device_locked === 1'b0, "27 matching bits locked");
        run(CMD_READ_LATCH, PORT_SWD, 2'h0, 32'h0, 1'b1, 1'b0, "swd read");
        chk(got_data === (KEY ^ 32'h0000_001F), "latch readback");
        run(CMD_ERASE_LATCH, PORT_JTAG, 2'h0, 32'h0, 1'b1, 1'b0, "erase open latch");
    endtask

    task automatic t_prot();
        run(CMD_SET_PROT, PORT_SWD, 2'h1, 32'h0000_0001, 1'b1, 1'b0, "set level");
        run(CMD_BLK_ERASE, PORT_SWD, 2'h1, 32'h0, 1'b0, 1'b0, "erase protected");
        run(CMD_BLK_VERIFY, PORT_SWD, 2'h1, 32'h0, 1'b1, 1'b1, "verify protected");
        run(CMD_BLK_PROGRAM, PORT_JTAG, 2'h2, 32'h0, 1'b1, 1'b1, "program free");
        run(CMD_LOAD_KEY, PORT_SWD, 2'h0, KEY, 1'b0, 1'b0, "key with prot");
        run(CMD_SET_PROT, PORT_SWD, 2'h1, 32'h0, 1'b1, 1'b0, "lower level");
        run(CMD_BLK_ERASE, PORT_SWD, 2'h1, 32'h0, 1'b0, 1'b0, "level lowered");
        run(CMD_SET_PROT, PORT_SWD, 2'h0, 32'h0000_0002, 1'b1, 1'b0, "full level");
        run(CMD_BLK_VERIFY, PORT_SWD, 2'h0, 32'h0, 1'b0, 1'b0, "verify full");
        run(CMD_DEV_PROGRAM, PORT_JTAG, 2'h0, 32'h0, 1'b0, 1'b0, "dev program prot");
        run(CMD_FULL_ERASE, PORT_JTAG, 2'h0, 32'h0, 1'b1, 1'b1, "jtag full erase");
        run(CMD_BLK_ERASE, PORT_SWD, 2'h1, 32'h0, 1'b1, 1'b1, "erase after clear");
        run(CMD_DEV_PROGRAM, PORT_JTAG, 2'h0, 32'h1234, 1'b1, 1'b1, "dev program");
        chk(got_op === MEM_DEV_PROGRAM, "dev program op");
        slow <= 1'b1;
        fail <= 1'b1;
        run(CMD_DEV_VERIFY, PORT_SWD, 2'h0, 32'h1234, 1'b0, 1'b1, "slow failing verify");
        chk(got_op === MEM_DEV_VERIFY, "dev verify op");
        slow <= 1'b0;
        fail <= 1'b0;
    endtask

    task automatic t_lock();
        run(CMD_LOAD_KEY, PORT_SWD, 2'h0, KEY ^ 32'h8100_0011, 1'b1, 1'b0, "load only");
        do_reset();
        chk(device_locked === 1'b0, "locked without commit");
        run(CMD_LOAD_KEY, PORT_SWD, 2'h0, KEY ^ 32'h8100_0011, 1'b1, 1'b0, "load 28");
        run(CMD_COMMIT_KEY, PORT_SWD, 2'h0, 32'h0, 1'b1, 1'b0, "commit 28");
        debug_mode_req <= 1'b1;
        test_mode_req  <= 1'b1;
        run(CMD_BLK_ERASE, PORT_JTAG, 2'h3, 32'h0, 1'b1, 1'b1, "access before reset");
        chk(device_locked === 1'b0 && debug_mode_en === 1'b1, "locked before reset");
        do_reset();
        chk(device_locked === 1'b1, "28 matching bits open");
        chk(debug_mode_en === 1'b0 && test_mode_en === 1'b0, "mode entry allowed");
        chk(jtag_port_en === 1'b0 && swd_port_en === 1'b0, "ports enabled");
        run(CMD_ERASE_LATCH, PORT_SWD, 2'h0, 32'h0, 1'b0, 1'b0, "latch erased");
        run(CMD_LOAD_KEY, PORT_SWD, 2'h0, 32'h0, 1'b0, 1'b0, "latch rewritten");
        run(CMD_DEV_VERIFY, PORT_JTAG, 2'h0, 32'h0, 1'b0, 1'b0, "locked verify");
        run(CMD_READ_LATCH, PORT_JTAG, 2'h0, 32'h0, 1'b0, 1'b0, "jtag read");
        run(CMD_READ_LATCH, PORT_SWD, 2'h0, 32'h0, 1'b1, 1'b0, "locked id read");
        chk(got_data === (KEY ^ 32'h8100_0011), "locked readback");
        do_reset();
        chk(device_locked === 1'b1, "lock lost at reset");
    endtask

    task automatic give_verdict();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        reset_n        = 1'b0;
        cmd_valid      = 1'b0;
        cmd_op         = CMD_LOAD_KEY;
        cmd_port       = PORT_SWD;
        cmd_block      = 2'h0;
        cmd_data       = 32'h0;
        slow           = 1'b0;
        fail           = 1'b0;
        test_mode_req  = 1'b0;
        debug_mode_req = 1'b0;
        t_init();
        t_near_miss();
        t_prot();
        t_lock();
        give_verdict();
    end

    // run needs under a thousand cycles
    initial begin
        #200_000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
